// >>> chcl_card_host.sv
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
module chcl_card_host (
  input  wire logic                     clk_sys,
  input  wire logic                     rst,
  input  wire logic [7:0]               reg_addr,
  input  wire logic [31:0]              reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [31:0]              reg_rdata,
  output logic                          irq,
  input  wire logic [chcl_pkg::NIRQ-1:0] evt_pulse,
  input  wire logic [chcl_pkg::NIRQ-1:0] evt_level,
  output logic                          cu_go,
  output logic      [31:0]              cu_cmd,
  output logic      [31:0]              cu_arg,
  output logic      [31:0]              cu_bytcnt,
  output logic      [15:0]              cu_blksiz,
  output logic      [31:0]              cu_tmout,
  output logic                          cu_ctype,
  output logic      [1:0]               cu_clksrc,
  input  wire logic                     cu_cmd_sent,
  input  wire logic                     cu_cmd_done,
  input  wire logic                     cu_data_done,
  output logic                          cclk_out,
  output logic                          buf_wr,
  output logic                          buf_rd,
  output logic      [31:0]              buf_wdata,
  input  wire logic [31:0]              buf_rdata,
  input  wire logic                     dma_wr,
  input  wire logic                     dma_rd,
  input  wire logic [31:0]              dma_wdata,
  output logic                          dma_ready,
  output logic      [31:0]              dma_rdata
);
  import chcl_pkg::*;

  chcl_bank_s      r_reg;
  chcl_bank_s      r_next;
  logic            locked;
  logic            lk_hit;
  logic            hle_ev;
  logic            bus_buf;
  logic [NIRQ-1:0] ev;
  logic [NIRQ-1:0] clr;
  logic [8:0]      half;
  logic [31:0]     status;

  chcl_cq_if cq ();

  // ----------------------------------------
  // Command queue
  // ----------------------------------------
  chcl_cmd_queue u_queue (
    .clk_sys (clk_sys),
    .rst     (rst),
    .q       (cq.queue)
  );

  // The launch bit itself is the request; the whole settings set rides with it
  assign cq.launch    = locked;
  assign cq.cfg_in    = r_reg.cfg;
  assign cq.cmd_sent  = cu_cmd_sent;
  assign cq.cmd_done  = cu_cmd_done;
  assign cq.data_done = cu_data_done;

  // ----------------------------------------
  // Lock decode
  // ----------------------------------------
  // Software is expected to poll the launch bit; the lock only guards mistakes
  always_comb
  begin
    locked = r_reg.cfg.cmd[CMD_START];
    case (reg_addr)
      OFS_CMD,
      OFS_CMDARG,
      OFS_BYTCNT,
      OFS_BLKSIZ,
      OFS_CLKDIV,
      OFS_CLKENA,
      OFS_CLKSRC,
      OFS_TMOUT,
      OFS_CTYPE: lk_hit = 1'b1;
      default:   lk_hit = 1'b0;
    endcase
    hle_ev = reg_wr && locked && lk_hit;
  end

  // ----------------------------------------
  // Event gathering
  // ----------------------------------------
  // Level sources keep setting their bit, so a clear only sticks once the source drops
  always_comb
  begin
    ev          = (evt_pulse & ~LVL_MASK) | (evt_level & LVL_MASK);
    ev[IRQ_HLE] = ev[IRQ_HLE] | hle_ev;
    clr         = '0;
    if (reg_wr && reg_addr == OFS_RINTSTS)
      clr = reg_wdata[NIRQ-1:0];
  end

  // ----------------------------------------
  // Status word
  // ----------------------------------------
  always_comb
  begin
    status            = '0;
    status[ST_LAUNCH] = locked;
    status[ST_SLOT]   = cq.slot_full;
    status[ST_DBUSY]  = cq.data_busy;
    status[ST_CBUSY]  = cq.cmd_busy;
  end

  // ----------------------------------------
  // Buffer port sharing
  // ----------------------------------------
  // Register access wins the buffer; DMA is told to wait for that one cycle
  always_comb
  begin
    bus_buf   = (reg_addr == OFS_DATA) && (reg_wr || reg_rd);
    dma_ready = !bus_buf;
    if (bus_buf)
    begin
      buf_wr    = reg_wr;
      buf_rd    = reg_rd;
      buf_wdata = reg_wdata;
    end
    else
    begin
      buf_wr    = dma_wr;
      buf_rd    = dma_rd;
      buf_wdata = dma_wdata;
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    r_next       = r_reg;
    r_next.rdata = '0;
    half         = 9'({1'b0, cq.cfg_out.clkdiv} + 9'h001);
    if (half < CCLK_MIN_HALF)
      half = CCLK_MIN_HALF;

    // Register writes; a locked target keeps its old value
    if (reg_wr && !(locked && lk_hit))
    begin
      case (reg_addr)
        OFS_CTRL:    r_next.ctrl       = reg_wdata;
        OFS_INTMASK: r_next.mask       = reg_wdata[NIRQ-1:0];
        OFS_CLKDIV:  r_next.cfg.clkdiv = reg_wdata[7:0];
        OFS_CLKSRC:  r_next.cfg.clksrc = reg_wdata[1:0];
        OFS_CLKENA:  r_next.cfg.clkena = reg_wdata[0];
        OFS_TMOUT:   r_next.cfg.tmout  = reg_wdata;
        OFS_CTYPE:   r_next.cfg.ctype  = reg_wdata[0];
        OFS_BLKSIZ:  r_next.cfg.blksiz = reg_wdata[15:0];
        OFS_BYTCNT:  r_next.cfg.bytcnt = reg_wdata;
        OFS_CMDARG:  r_next.cfg.arg    = reg_wdata;
        OFS_CMD:     r_next.cfg.cmd    = reg_wdata;
        default:     r_next.ctrl       = r_reg.ctrl;
      endcase
    end

    // Acceptance drops the launch bit and with it the lock
    if (cq.accept)
      r_next.cfg.cmd[CMD_START] = 1'b0;

    // Set beats clear so an event in the clearing cycle survives
    r_next.rint = (r_reg.rint & ~clr) | ev;

    // Register reads, answered in the next cycle
    if (reg_rd)
    begin
      case (reg_addr)
        OFS_CTRL:    r_next.rdata = r_reg.ctrl;
        OFS_INTMASK: r_next.rdata = 32'(r_reg.mask);
        OFS_RINTSTS: r_next.rdata = 32'(r_reg.rint);
        OFS_STATUS:  r_next.rdata = status;
        OFS_CLKDIV:  r_next.rdata = 32'(r_reg.cfg.clkdiv);
        OFS_CLKSRC:  r_next.rdata = 32'(r_reg.cfg.clksrc);
        OFS_CLKENA:  r_next.rdata = 32'(r_reg.cfg.clkena);
        OFS_TMOUT:   r_next.rdata = r_reg.cfg.tmout;
        OFS_CTYPE:   r_next.rdata = 32'(r_reg.cfg.ctype);
        OFS_BLKSIZ:  r_next.rdata = 32'(r_reg.cfg.blksiz);
        OFS_BYTCNT:  r_next.rdata = r_reg.cfg.bytcnt;
        OFS_CMDARG:  r_next.rdata = r_reg.cfg.arg;
        OFS_CMD:     r_next.rdata = r_reg.cfg.cmd;
        OFS_DATA:    r_next.rdata = buf_rdata;
        default:     r_next.rdata = '0;
      endcase
    end

    // DMA read data is held until the next DMA read
    if (dma_rd && !bus_buf)
      r_next.dma_rdata = buf_rdata;

    // Card clock divider; half period is at least one cycle, so at most 25 MHz
    if (!cq.cfg_out.clkena)
    begin
      r_next.cdiv = '0;
      r_next.cclk = 1'b0;
    end
    else if (r_reg.cdiv >= 9'(half - 9'h001))
    begin
      r_next.cdiv = '0;
      r_next.cclk = !r_reg.cclk;
    end
    else
      r_next.cdiv = 9'(r_reg.cdiv + 9'h001);
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Every register software writes sits here, on clk_sys only
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      r_reg            <= '0;
      r_reg.mask       <= MASK_RST;
      r_reg.cfg.tmout  <= TMOUT_RST;
      r_reg.cfg.blksiz <= BLKSIZ_RST;
      r_reg.cfg.bytcnt <= BYTCNT_RST;
    end
    else
      r_reg <= r_next;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // The card unit frames each token with start and stop bits on its own lines
  assign cu_go     = cq.go;
  assign cu_cmd    = cq.cfg_out.cmd;
  assign cu_arg    = cq.cfg_out.arg;
  assign cu_bytcnt = cq.cfg_out.bytcnt;
  assign cu_blksiz = cq.cfg_out.blksiz;
  assign cu_tmout  = cq.cfg_out.tmout;
  assign cu_ctype  = cq.cfg_out.ctype;
  assign cu_clksrc = cq.cfg_out.clksrc;
  assign cclk_out  = r_reg.cclk;
  assign reg_rdata = r_reg.rdata;
  assign dma_rdata = r_reg.dma_rdata;

  // Interrupt level straight from flops
  assign irq = r_reg.ctrl[CTRL_INTEN] && |(r_reg.rint & r_reg.mask);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_lock;
    reg_wr && locked && reg_addr == OFS_CMDARG |=> r_reg.cfg.arg == $past(r_reg.cfg.arg);
  endproperty
  a_lock: assert property (p_lock) else $error("locked argument overwritten");
  property p_clr;
    cq.accept |=> !r_reg.cfg.cmd[CMD_START];
  endproperty
  a_clr: assert property (p_clr) else $error("launch bit kept after accept");
  property p_hle;
    hle_ev |=> r_reg.rint[IRQ_HLE];
  endproperty
  a_hle: assert property (p_hle) else $error("lock error flag not set");
  property p_sticky;
    r_reg.rint[IRQ_HLE] && !clr[IRQ_HLE] |=> r_reg.rint[IRQ_HLE];
  endproperty
  a_sticky: assert property (p_sticky) else $error("status bit dropped without clear");
  property p_w1c;
    clr[IRQ_HLE] && !ev[IRQ_HLE] |=> !r_reg.rint[IRQ_HLE];
  endproperty
  a_w1c: assert property (p_w1c) else $error("status bit not cleared");
  property p_irq;
    irq |-> r_reg.ctrl[CTRL_INTEN] && (r_reg.rint & r_reg.mask) != '0;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt without cause");
  property p_por;
    @(posedge clk_sys) disable iff (1'b0) rst |=> !r_reg.ctrl[CTRL_INTEN] && r_reg.mask == '0;
  endproperty
  a_por: assert property (p_por) else $error("interrupts not masked after reset");
  property p_free;
    reg_wr && !locked && reg_addr == OFS_CMDARG |=> r_reg.cfg.arg == $past(reg_wdata);
  endproperty
  a_free: assert property (p_free) else $error("unlocked write lost");

  // Lock hold, status set, interrupt level, buffer and card clock checks
  property p_lock_to;
    reg_wr && locked && reg_addr == OFS_TMOUT |=> r_reg.cfg.tmout == $past(r_reg.cfg.tmout);
  endproperty
  a_lock_to: assert property (p_lock_to) else $error("locked timeout overwritten");
  property p_keep;
    locked && !cq.accept |=> r_reg.cfg.cmd[CMD_START];
  endproperty
  a_keep: assert property (p_keep) else $error("launch bit dropped before accept");
  property p_set;
    ev != '0 |=> (r_reg.rint & $past(ev)) == $past(ev);
  endproperty
  a_set: assert property (p_set) else $error("event did not set its status bit");
  property p_lvl;
    (evt_level & LVL_MASK) != '0 |=> (r_reg.rint & $past(evt_level & LVL_MASK)) == $past(evt_level & LVL_MASK);
  endproperty
  a_lvl: assert property (p_lvl) else $error("level source did not hold its bit");
  property p_irq_on;
    r_reg.ctrl[CTRL_INTEN] && (r_reg.rint & r_reg.mask) != '0 |-> irq;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("enabled unmasked cause without interrupt");
  property p_dma;
    dma_rd && dma_ready |=> dma_rdata == $past(buf_rdata);
  endproperty
  a_dma: assert property (p_dma) else $error("granted DMA read lost");
  property p_cclk_off;
    !cq.cfg_out.clkena |=> !cclk_out;
  endproperty
  a_cclk_off: assert property (p_cclk_off) else $error("card clock runs while disabled");
  property p_free_to;
    reg_wr && !locked && reg_addr == OFS_TMOUT |=> r_reg.cfg.tmout == $past(reg_wdata);
  endproperty
  a_free_to: assert property (p_free_to) else $error("unlocked timeout write lost");

endmodule : chcl_card_host

// >>> chcl_card_host_bench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module chcl_card_host_bench;
  import chcl_pkg::*;
  localparam logic [31:0] BUF_WORD = 32'h5a5ac3c3;
  localparam logic [31:0] START    = 32'h80000000;
  logic            clk_sys, rst, reg_wr, reg_rd, irq;
  logic [7:0]      reg_addr;
  logic [31:0]     reg_wdata, reg_rdata, cu_cmd, cu_arg;
  logic [NIRQ-1:0] evt_pulse, evt_level;
  logic            cu_go, cu_cmd_sent, cu_cmd_done, cu_data_done;
  logic [31:0]     cu_bytcnt, cu_tmout, buf_wdata, dma_wdata, dma_rdata;
  logic [15:0]     cu_blksiz;
  logic [1:0]      cu_clksrc;
  logic            cu_ctype, cclk_out, cclk_prev, buf_wr, buf_rd, dma_wr, dma_rd, dma_ready;
  int              fail_count, n_compared, cyc, ng, dd_last, b, n_tog;
  int              go_cyc[16], sent_cyc[16], done_cyc[16];
  logic [31:0]     go_arg[16];
  logic [7:0]      lk_ofs[4] = '{OFS_CMDARG, OFS_TMOUT, OFS_BLKSIZ, OFS_BYTCNT};
  logic [31:0]     lk_val[4] = '{32'h0000abcd, TMOUT_RST, 32'(BLKSIZ_RST), BYTCNT_RST};

  // ----------------------------------------
  // Design and card unit
  // ----------------------------------------
  chcl_card_host i_dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .evt_pulse(evt_pulse),
    .evt_level(evt_level), .cu_go(cu_go), .cu_cmd(cu_cmd), .cu_arg(cu_arg), .cu_bytcnt(cu_bytcnt),
    .cu_blksiz(cu_blksiz), .cu_tmout(cu_tmout), .cu_ctype(cu_ctype), .cu_clksrc(cu_clksrc),
    .cu_cmd_sent(cu_cmd_sent), .cu_cmd_done(cu_cmd_done), .cu_data_done(cu_data_done), .cclk_out(cclk_out),
    .buf_wr(buf_wr), .buf_rd(buf_rd), .buf_wdata(buf_wdata), .buf_rdata(BUF_WORD), .dma_wr(dma_wr),
    .dma_rd(dma_rd), .dma_wdata(dma_wdata), .dma_ready(dma_ready), .dma_rdata(dma_rdata));
  chcl_cu_model i_cu (.clk_sys(clk_sys), .rst(rst), .go(cu_go), .cmd_w(cu_cmd), .sent(cu_cmd_sent),
    .done(cu_cmd_done), .data_done(cu_data_done));

  // Log when each command goes and what the card unit answered
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cu_go === 1'b1)
    begin
      go_cyc[ng] <= cyc;
      go_arg[ng] <= cu_arg;
      ng <= ng + 1;
    end
    if (cu_cmd_sent) sent_cyc[ng-1] <= cyc;
    if (cu_cmd_done) done_cyc[ng-1] <= cyc;
    if (cu_data_done) dd_last <= cyc;
  end

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clk_sys);
  endtask : rd

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    `CHK("reg_rdata", e, d)
  endtask : chk_rd

  // Software waits for the launch bit to drop before touching the copied registers
  task automatic launch(input logic [31:0] c);
    logic [31:0] d;
    int k;
    wr(OFS_CMD, START | c);
    d = 32'h1;
    k = 0;
    while (d[ST_LAUNCH] !== 1'b0 && k < 100)
    begin
      rd(OFS_STATUS, d);
      k++;
    end
    `CHK("launch_bit", 1'b0, d[ST_LAUNCH])
  endtask : launch

  task automatic wait_go(input int n);
    int k;
    k = 0;
    while (ng < n && k < 300)
    begin
      @(posedge clk_sys);
      k++;
    end
    `CHK("go_count", n, ng)
  endtask : wait_go

  task automatic end_of_test;
    if (fail_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  // ----------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Whole run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    fail_count++;
    end_of_test();
  end

  initial
  begin
    logic [31:0] d;
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    evt_pulse = '0;
    evt_level = '0;
    dma_wr = 1'b0;
    dma_rd = 1'b0;
    dma_wdata = 32'h0;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    // Reset state, unmapped and buffer reads, plain writes
    `CHK("irq", 1'b0, irq)
    chk_rd(OFS_CTRL, 32'h0);
    chk_rd(OFS_INTMASK, 32'h0);
    chk_rd(8'hfc, 32'h0);
    chk_rd(OFS_DATA, BUF_WORD);
    // DMA reads the buffer, then holds its write while a register write owns the buffer
    dma_rd <= 1'b1;
    @(posedge clk_sys);
    `CHK("buf_rd", 1'b1, buf_rd)
    dma_rd <= 1'b0;
    dma_wr <= 1'b1;
    dma_wdata <= 32'h0000c0de;
    reg_addr <= OFS_DATA;
    reg_wdata <= 32'h00001234;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    `CHK("dma_rdata", BUF_WORD, dma_rdata)
    `CHK("dma_ready", 1'b0, dma_ready)
    `CHK("buf_wdata", 32'h00001234, buf_wdata)
    reg_wr <= 1'b0;
    @(posedge clk_sys);
    `CHK("dma_ready", 1'b1, dma_ready)
    `CHK("buf_wr", 1'b1, buf_wr)
    `CHK("buf_wdata", 32'h0000c0de, buf_wdata)
    dma_wr <= 1'b0;
    wr(OFS_CMDARG, 32'h0000abcd);
    wr(OFS_CTYPE, 32'h1);
    wr(OFS_CLKSRC, 32'h2);
    wr(OFS_CLKDIV, 32'h1);
    wr(OFS_CLKENA, 32'h1);
    chk_rd(OFS_CLKSRC, 32'h2);
    for (int i = 0; i < 4; i++) chk_rd(lk_ofs[i], lk_val[i]);
    // Command without data, then one queued behind it
    b = ng;
    launch(32'h0);
    launch(32'h0);
    wait_go(b + 2);
    `CHK("go_after_done", 1'b1, go_cyc[b+1] > done_cyc[b])
    `CHK("go_soon_after_done", 1'b1, go_cyc[b+1] <= done_cyc[b] + 2)
    `CHK("cu_ctype", 1'b1, cu_ctype)
    `CHK("cu_clksrc", 2'h2, cu_clksrc)
    `CHK("cu_tmout", TMOUT_RST, cu_tmout)
    `CHK("cu_blksiz", BLKSIZ_RST, cu_blksiz)
    `CHK("cu_bytcnt", BYTCNT_RST, cu_bytcnt)
    // Divider of one gives a half period of two system cycles
    n_tog = 0;
    cclk_prev = cclk_out;
    repeat (8)
    begin
      @(posedge clk_sys);
      if (cclk_out !== cclk_prev)
        n_tog++;
      cclk_prev = cclk_out;
    end
    `CHK("cclk_toggles", 4, n_tog)
    repeat (80) @(posedge clk_sys);
    // Data command, then one that does not wait for the data
    b = ng;
    launch(32'h1 << CMD_DATA);
    launch(32'h0);
    wait_go(b + 2);
    repeat (80) @(posedge clk_sys);
    `CHK("go_after_sent", 1'b1, go_cyc[b+1] > sent_cyc[b])
    `CHK("go_soon_after_sent", 1'b1, go_cyc[b+1] <= sent_cyc[b] + 2)
    `CHK("go_during_data", 1'b1, go_cyc[b+1] < dd_last)
    // Data command, a waiting one, and a third held off while the slot is full
    b = ng;
    launch(32'h1 << CMD_DATA);
    launch(32'h1 << CMD_WAIT);
    wr(OFS_CMD, START);
    rd(OFS_STATUS, d);
    `CHK("launch_and_slot", 2'b11, d[1:0])
    for (int i = 0; i < 4; i++) wr(lk_ofs[i], 32'h0);
    for (int i = 0; i < 4; i++) chk_rd(lk_ofs[i], lk_val[i]);
    chk_rd(OFS_RINTSTS, 32'h00001000);
    wait_go(b + 3);
    `CHK("go_after_data", 1'b1, go_cyc[b+1] > dd_last)
    `CHK("cu_arg", 32'h0000abcd, go_arg[b+2])
    // Raw status, mask and enable
    wr(OFS_RINTSTS, 32'h0);
    chk_rd(OFS_RINTSTS, 32'h00001000);
    wr(OFS_RINTSTS, 32'h00001000);
    chk_rd(OFS_RINTSTS, 32'h0);
    evt_pulse <= 17'h00004;
    @(posedge clk_sys);
    evt_pulse <= '0;
    chk_rd(OFS_RINTSTS, 32'h4);
    `CHK("irq", 1'b0, irq)
    wr(OFS_INTMASK, 32'h4);
    `CHK("irq", 1'b0, irq)
    wr(OFS_CTRL, 32'h10);
    `CHK("irq", 1'b1, irq)
    wr(OFS_INTMASK, 32'h0);
    `CHK("irq", 1'b0, irq)
    wr(OFS_INTMASK, 32'h4);
    wr(OFS_RINTSTS, 32'h4);
    `CHK("irq", 1'b0, irq)
    // A level source refuses to clear while it is still high
    evt_level <= 17'h00020;
    wr(OFS_RINTSTS, 32'h20);
    chk_rd(OFS_RINTSTS, 32'h20);
    evt_level <= '0;
    wr(OFS_RINTSTS, 32'h20);
    chk_rd(OFS_RINTSTS, 32'h0);
    end_of_test();
  end
endmodule : chcl_card_host_bench

// >>> chcl_cmd_queue.sv
`timescale 1ns/1ps
module chcl_cmd_queue (
  input wire logic clk_sys,
  input wire logic rst,
  chcl_cq_if.queue q
);
  import chcl_pkg::*;

  chcl_cq_s r_reg;
  chcl_cq_s r_next;
  logic     accept;
  logic     issue;
  logic     wt;

  // ----------------------------------------
  // Queue control
  // ----------------------------------------
  // One slot only; a launch waits while the slot is taken
  always_comb
  begin
    wt     = r_reg.pend.cmd[CMD_WAIT];
    accept = q.launch && !r_reg.slot;
    // Waiting commands need the link idle and data done; others may overlap data
    issue  = r_reg.slot && (r_reg.st != CQ_SEND) &&
             (wt ? (!r_reg.dbusy && r_reg.st == CQ_IDLE) :
                   (r_reg.st == CQ_IDLE || r_reg.dbusy));
    r_next    = r_reg;
    r_next.go = issue;
    if (q.data_done)
      r_next.dbusy = 1'b0;
    case (r_reg.st)
      CQ_IDLE: r_next.st = CQ_IDLE;
      CQ_SEND: if (q.cmd_sent) r_next.st = CQ_RESP;
      CQ_RESP: if (q.cmd_done) r_next.st = CQ_IDLE;
      default: r_next.st = CQ_IDLE;
    endcase
    if (issue)
    begin
      r_next.act  = r_reg.pend;
      r_next.slot = 1'b0;
      r_next.st   = CQ_SEND;
      if (r_reg.pend.cmd[CMD_DATA])
        r_next.dbusy = 1'b1;
    end
    if (accept)
    begin
      r_next.slot = 1'b1;
      r_next.pend = q.cfg_in;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  // Accept is a handshake term, the rest come from flops
  assign q.accept    = accept;
  assign q.go        = r_reg.go;
  assign q.cfg_out   = r_reg.act;
  assign q.slot_full = r_reg.slot;
  assign q.data_busy = r_reg.dbusy;
  assign q.cmd_busy  = (r_reg.st != CQ_IDLE);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_issue;
    issue;
  endsequence
  sequence s_sent;
    q.go && q.cfg_out == $past(r_reg.pend);
  endsequence

  property p_copy;
    accept |=> r_reg.pend == $past(q.cfg_in);
  endproperty
  a_copy: assert property (p_copy) else $error("launch copy lost");
  property p_deep;
    s_issue |=> s_sent;
  endproperty
  a_deep: assert property (p_deep) else $error("queued command not sent");
  property p_nodata;
    r_reg.slot && r_reg.st == CQ_IDLE && !r_reg.dbusy |-> issue;
  endproperty
  a_nodata: assert property (p_nodata) else $error("idle link but no send");
  property p_wait;
    r_reg.slot && r_reg.dbusy && wt |-> !issue;
  endproperty
  a_wait: assert property (p_wait) else $error("sent before data done");
  property p_nowait;
    r_reg.slot && r_reg.st == CQ_RESP && r_reg.dbusy && !wt |-> issue;
  endproperty
  a_nowait: assert property (p_nowait) else $error("non-waiting command held");

endmodule : chcl_cmd_queue

// >>> chcl_cq_if.sv
`timescale 1ns/1ps
interface chcl_cq_if;
  import chcl_pkg::*;
  logic      launch;
  logic      accept;
  chcl_cfg_s cfg_in;
  chcl_cfg_s cfg_out;
  logic      go;
  logic      slot_full;
  logic      data_busy;
  logic      cmd_busy;
  logic      cmd_sent;
  logic      cmd_done;
  logic      data_done;

  modport bank (output launch, cfg_in, cmd_sent, cmd_done, data_done,
                input accept, cfg_out, go, slot_full, data_busy, cmd_busy);
  modport queue (input launch, cfg_in, cmd_sent, cmd_done, data_done,
                 output accept, cfg_out, go, slot_full, data_busy, cmd_busy);
endinterface : chcl_cq_if

// >>> chcl_cu_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Card unit stand-in
// ----------------------------------------
module chcl_cu_model
  import chcl_pkg::*;
#(
  parameter int SENT_AT = 4,
  parameter int DONE_AT = 8,
  parameter int DATA_AT = 60
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        go,
  input  wire logic [31:0] cmd_w,
  output logic             sent,
  output logic             done,
  output logic             data_done
);
  int cc;
  int dc;

  // Separate counters so a queued command may overlap a transfer;
  // a new command restarts the command phase like an abort would
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cc <= 0;
      dc <= 0;
    end
    else
    begin
      cc <= go ? 1 : (cc == 0 || cc == DONE_AT) ? 0 : cc + 1;
      dc <= (go && cmd_w[CMD_DATA]) ? 1 : (dc == 0 || dc == DATA_AT) ? 0 : dc + 1;
    end
  end

  // Answers are one-cycle pulses
  assign sent      = (cc == SENT_AT);
  assign done      = (cc == DONE_AT);
  assign data_done = (dc == DATA_AT);
endmodule : chcl_cu_model

// >>> chcl_pkg.sv
package chcl_pkg;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_CLKDIV  = 8'h08;
  localparam logic [7:0] OFS_CLKSRC  = 8'h0c;
  localparam logic [7:0] OFS_CLKENA  = 8'h10;
  localparam logic [7:0] OFS_TMOUT   = 8'h14;
  localparam logic [7:0] OFS_CTYPE   = 8'h18;
  localparam logic [7:0] OFS_BLKSIZ  = 8'h1c;
  localparam logic [7:0] OFS_BYTCNT  = 8'h20;
  localparam logic [7:0] OFS_INTMASK = 8'h24;
  localparam logic [7:0] OFS_CMDARG  = 8'h28;
  localparam logic [7:0] OFS_CMD     = 8'h2c;
  localparam logic [7:0] OFS_RINTSTS = 8'h44;
  localparam logic [7:0] OFS_STATUS  = 8'h48;
  localparam logic [7:0] OFS_DATA    = 8'h80;

  // ----------------------------------------
  // Field positions and widths
  // ----------------------------------------
  localparam int NIRQ       = 17;
  localparam int CMD_START  = 31;
  localparam int CMD_WAIT   = 13;
  localparam int CMD_DATA   = 9;
  localparam int CTRL_INTEN = 4;
  localparam int IRQ_HLE    = 12;
  localparam int ST_LAUNCH  = 0;
  localparam int ST_SLOT    = 1;
  localparam int ST_DBUSY   = 2;
  localparam int ST_CBUSY   = 3;
  // SDIO, receive request and transmit request follow level sources
  localparam logic [NIRQ-1:0] LVL_MASK = 17'h10030;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [NIRQ-1:0] MASK_RST   = 17'h00000;
  localparam logic [31:0]     TMOUT_RST  = 32'hffffff40;
  localparam logic [15:0]     BLKSIZ_RST = 16'h0200;
  localparam logic [31:0]     BYTCNT_RST = 32'h00000200;

  // ----------------------------------------
  // Card clock limit
  // ----------------------------------------
  localparam longint SYS_HZ      = 50_000_000;
  localparam longint CCLK_MAX_HZ = 50_000_000;
  localparam logic [8:0] CCLK_MIN_HALF = 9'((SYS_HZ + 2 * CCLK_MAX_HZ - 1) / (2 * CCLK_MAX_HZ));

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic [31:0] cmd;
    logic [31:0] arg;
    logic [31:0] bytcnt;
    logic [15:0] blksiz;
    logic [7:0]  clkdiv;
    logic [1:0]  clksrc;
    logic        clkena;
    logic [31:0] tmout;
    logic        ctype;
  } chcl_cfg_s;

  typedef enum logic [1:0] {
    CQ_IDLE = 2'b00,
    CQ_SEND = 2'b01,
    CQ_RESP = 2'b10
  } chcl_cq_e;

  typedef struct packed {
    chcl_cq_e  st;
    logic      slot;
    logic      dbusy;
    logic      go;
    chcl_cfg_s pend;
    chcl_cfg_s act;
  } chcl_cq_s;

  typedef struct packed {
    logic [31:0]     ctrl;
    logic [NIRQ-1:0] mask;
    logic [NIRQ-1:0] rint;
    chcl_cfg_s       cfg;
    logic [31:0]     rdata;
    logic [31:0]     dma_rdata;
    logic [8:0]      cdiv;
    logic            cclk;
  } chcl_bank_s;

endpackage : chcl_pkg
